// ### hdl/dgb_pkg.sv
// constants for the q-path gain, soft blanking and sequence checker slice
// assumes byte-wide register access on 12-bit addresses
package dgb_pkg;
  localparam int SAMPLE_W = 16;
  localparam int GAIN_W = 12;
  localparam int GAIN_FRAC = 11;
  localparam int ERR_W = 8;
  localparam int SEQ_W = 15;
  localparam int SAMPLE_BIT = 15;

  localparam logic [11:0] ADR_Q_GAIN_LOW = 12'h13e;
  localparam logic [11:0] ADR_Q_GAIN_HIGH = 12'h13f;
  localparam logic [11:0] ADR_UP_LOW = 12'h140;
  localparam logic [11:0] ADR_UP_HIGH = 12'h141;
  localparam logic [11:0] ADR_DN_LOW = 12'h142;
  localparam logic [11:0] ADR_DN_HIGH = 12'h143;
  localparam logic [11:0] ADR_CFG_ONE = 12'h146;
  localparam logic [11:0] ADR_BLANK = 12'h147;
  localparam logic [11:0] ADR_CHK_CTRL = 12'h14b;
  localparam logic [11:0] ADR_ERR_REAL = 12'h14c;
  localparam logic [11:0] ADR_ERR_IMAG = 12'h14d;

  localparam logic [7:0] RST_Q_GAIN_LOW = 8'hea;
  localparam logic [3:0] RST_Q_GAIN_HIGH = 4'ha;
  localparam logic [7:0] RST_UP_LOW = 8'h04;
  localparam logic [3:0] RST_UP_HIGH = 4'h0;
  localparam logic [7:0] RST_DN_LOW = 8'h09;
  localparam logic [3:0] RST_DN_HIGH = 4'h0;
  localparam logic [7:0] RST_CFG_ONE = 8'h00;

  localparam int FLD_IMAG_OK = 7;
  localparam int FLD_REAL_OK = 6;
  localparam int FLD_POLY = 2;
  localparam int FLD_CLR = 1;
  localparam int FLD_EN = 0;

  localparam logic [1:0] RB_BLANKED = 2'h0;
  localparam logic [1:0] RB_RAMP_DOWN = 2'h1;
  localparam logic [1:0] RB_RAMP_UP = 2'h2;
  localparam logic [1:0] RB_DATA = 2'h3;

  localparam logic [11:0] GAIN_UNITY = 12'h800;
  localparam logic [7:0] ERR_MAX = 8'hff;

  typedef enum logic [1:0] {
    ST_BLANKED,
    ST_RAMP_DOWN,
    ST_RAMP_UP,
    ST_DATA
  } dgb_blank_e;
endpackage

// ### hdl/dgb_gain_mul.sv
// q-path digital gain multiplier with saturation
// assumes gain code with 11 fractional bits, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module dgb_gain_mul
  import dgb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [GAIN_W-1:0] gain_in,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic valid_out
);
  typedef struct packed {
    logic [SAMPLE_W-1:0] y;
    logic v;
  } dgb_mul_s;

  dgb_mul_s m_q;
  dgb_mul_s m_d;
  logic signed [28:0] prod;
  logic signed [17:0] scaled;

  always_comb
  begin
    m_d = m_q;
    prod = $signed(sample_in) * $signed({1'b0, gain_in}); // [R01]
    scaled = prod[28:GAIN_FRAC];
    m_d.v = valid_in;
    if (valid_in)
    begin
      if (scaled > 18'sh07fff)
        m_d.y = 16'h7fff;
      else if (scaled < -18'sh08000)
        m_d.y = 16'h8000;
      else
        m_d.y = scaled[15:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      m_q <= '0;
    else
      m_q <= m_d;
  end

  assign sample_out = m_q.y;
  assign valid_out = m_q.v;

  property p_unity;
    @(posedge clk_in) disable iff (rst_in)
    (valid_in && gain_in == GAIN_UNITY)
      |=> (valid_out && sample_out == $past(sample_in));
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered"); // [R01]

  property p_zero;
    @(posedge clk_in) disable iff (rst_in)
    (valid_in && gain_in == 12'h000) |=> sample_out == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero gain not zero"); // [R01]
endmodule
`default_nettype wire

// ### hdl/dgb_seq_chk.sv
// one-channel pseudo-random sequence checker with error counter
// assumes one checked bit per valid sample, self-synchronising reference
`timescale 1ns/1ps
`default_nettype none
module dgb_seq_chk
  import dgb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic poly_in,
  input wire logic clear_in,
  input wire logic valid_in,
  input wire logic bit_in,
  output logic seq_ok_out,
  output logic [ERR_W-1:0] err_count_out
);
  typedef struct packed {
    logic [SEQ_W-1:0] sh;
    logic ok;
    logic [ERR_W-1:0] cnt;
  } dgb_chk_s;

  dgb_chk_s c_q;
  dgb_chk_s c_d;
  logic expect_bit;

  always_comb
  begin
    c_d = c_q;
    expect_bit = poly_in ? (c_q.sh[14] ^ c_q.sh[13])
                         : (c_q.sh[6] ^ c_q.sh[5]); // [R07]
    if (enable_in && valid_in) // [R06]
    begin
      c_d.sh = {c_q.sh[SEQ_W-2:0], bit_in};
      c_d.ok = (bit_in == expect_bit); // [R09]
      if (bit_in != expect_bit && c_q.cnt != ERR_MAX) // [R11]
        c_d.cnt = c_q.cnt + 8'h01; // [R10]
    end
    if (clear_in)
      c_d.cnt = '0; // [R08]
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  assign seq_ok_out = c_q.ok;
  assign err_count_out = c_q.cnt;

  default clocking dgb_chk_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_clear;
    clear_in |=> err_count_out == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed"); // [R08]

  property p_idle;
    (!enable_in && !clear_in) |=> ($stable(err_count_out) && $stable(seq_ok_out));
  endproperty
  a_idle: assert property (p_idle) else $error("checker ran disabled"); // [R06]

  property p_miss;
    (enable_in && valid_in && !clear_in && bit_in != expect_bit
      && err_count_out != ERR_MAX)
      |=> (err_count_out == $past(err_count_out) + 8'h01) && !seq_ok_out;
  endproperty
  a_miss: assert property (p_miss) else $error("mismatch not counted"); // [R10]

  property p_sat;
    (err_count_out == ERR_MAX && !clear_in) |=> err_count_out == ERR_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped"); // [R11]

  property p_match7;
    (enable_in && valid_in && !poly_in && bit_in == (c_q.sh[6] ^ c_q.sh[5]))
      |=> seq_ok_out;
  endproperty
  a_match7: assert property (p_match7) else $error("good flag low"); // [R09]

  property p_match15;
    (enable_in && valid_in && poly_in && bit_in == (c_q.sh[14] ^ c_q.sh[13])
      && !clear_in) |=> (seq_ok_out && $stable(err_count_out));
  endproperty
  a_match15: assert property (p_match15) else $error("long poly wrong"); // [R07]

  c_sat: cover property (err_count_out == ERR_MAX);
  c_ok: cover property (enable_in && seq_ok_out [*8]);
endmodule
`default_nettype wire

// ### hdl/dgb_datapath.sv
// q-path gain with soft blanking ramps, and sequence checkers on both channels
// assumes byte register port, samples synchronous to the dac clock
//
// What this block does
// [R01] q samples scaled by gain code over 2048
// [R02] ramp up advances by up-step code plus one
// [R03] ramp down reduces by down-step code plus one
// [R04] blanking state readable as two-bit code
// [R05] software writes 0x01 into config one
// [R06] checker runs only while enable bit set
// [R07] polynomial bit picks 7 or 15 bit
// [R08] clear bit zeroes both error counters
// [R09] per-channel good flags at bits 7, 6
// [R10] eight-bit error count per channel
// [R11] error counters saturate at 255
// [R12] request ramps down, release ramps back up
`timescale 1ns/1ps
`default_nettype none
module dgb_datapath
  import dgb_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  input wire logic BLANK_REQ_IN,
  input wire logic SAMPLE_VALID_IN,
  input wire logic [SAMPLE_W-1:0] SAMPLE_REAL_IN,
  input wire logic [SAMPLE_W-1:0] SAMPLE_IMAG_IN,
  output logic [SAMPLE_W-1:0] Q_OUT,
  output logic Q_VALID_OUT
);
  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [GAIN_W-1:0] up;
    logic [GAIN_W-1:0] dn;
    logic [7:0] cfg1;
    logic poly;
    logic clr;
    logic en;
    dgb_blank_e st;
    logic [GAIN_W-1:0] cur;
    logic [7:0] rdata;
    logic rvalid;
  } dgb_top_s;

  dgb_top_s r_q;
  dgb_top_s r_d;
  logic [1:0] blank_code;
  logic real_ok;
  logic imag_ok;
  logic [ERR_W-1:0] real_cnt;
  logic [ERR_W-1:0] imag_cnt;
  logic [12:0] step_up;
  logic [12:0] step_dn;
  logic [12:0] up_sum;

  always_comb
  begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    step_up = {1'b0, r_q.up} + 13'h0001; // [R02]
    step_dn = {1'b0, r_q.dn} + 13'h0001; // [R03]
    up_sum = {1'b0, r_q.cur} + step_up;
    case (r_q.st)
      ST_BLANKED: blank_code = RB_BLANKED; // [R04]
      ST_RAMP_DOWN: blank_code = RB_RAMP_DOWN;
      ST_RAMP_UP: blank_code = RB_RAMP_UP;
      default: blank_code = RB_DATA;
    endcase

    // register writes; read-only locations ignore writes
    if (REG_WR_IN)
    begin
      if (REG_ADDR_IN == ADR_Q_GAIN_LOW)
        r_d.gain[7:0] = REG_WDATA_IN;
      else if (REG_ADDR_IN == ADR_Q_GAIN_HIGH)
        r_d.gain[11:8] = REG_WDATA_IN[3:0];
      else if (REG_ADDR_IN == ADR_UP_LOW)
        r_d.up[7:0] = REG_WDATA_IN;
      else if (REG_ADDR_IN == ADR_UP_HIGH)
        r_d.up[11:8] = REG_WDATA_IN[3:0];
      else if (REG_ADDR_IN == ADR_DN_LOW)
        r_d.dn[7:0] = REG_WDATA_IN;
      else if (REG_ADDR_IN == ADR_DN_HIGH)
        r_d.dn[11:8] = REG_WDATA_IN[3:0];
      else if (REG_ADDR_IN == ADR_CFG_ONE)
        r_d.cfg1 = REG_WDATA_IN; // [R05]
      else if (REG_ADDR_IN == ADR_CHK_CTRL)
      begin
        r_d.poly = REG_WDATA_IN[FLD_POLY]; // [R07]
        r_d.clr = REG_WDATA_IN[FLD_CLR]; // [R08]
        r_d.en = REG_WDATA_IN[FLD_EN]; // [R06]
      end
    end

    // register reads, answered one cycle later
    if (REG_RD_IN)
    begin
      r_d.rvalid = 1'b1;
      if (REG_ADDR_IN == ADR_Q_GAIN_LOW)
        r_d.rdata = r_q.gain[7:0];
      else if (REG_ADDR_IN == ADR_Q_GAIN_HIGH)
        r_d.rdata = {4'h0, r_q.gain[11:8]};
      else if (REG_ADDR_IN == ADR_UP_LOW)
        r_d.rdata = r_q.up[7:0];
      else if (REG_ADDR_IN == ADR_UP_HIGH)
        r_d.rdata = {4'h0, r_q.up[11:8]};
      else if (REG_ADDR_IN == ADR_DN_LOW)
        r_d.rdata = r_q.dn[7:0];
      else if (REG_ADDR_IN == ADR_DN_HIGH)
        r_d.rdata = {4'h0, r_q.dn[11:8]};
      else if (REG_ADDR_IN == ADR_CFG_ONE)
        r_d.rdata = r_q.cfg1;
      else if (REG_ADDR_IN == ADR_BLANK)
        r_d.rdata = {blank_code, 6'h00}; // [R04]
      else if (REG_ADDR_IN == ADR_CHK_CTRL)
        r_d.rdata = {imag_ok, real_ok, 3'h0, r_q.poly, r_q.clr,
                     r_q.en}; // [R09]
      else if (REG_ADDR_IN == ADR_ERR_REAL)
        r_d.rdata = real_cnt; // [R10]
      else if (REG_ADDR_IN == ADR_ERR_IMAG)
        r_d.rdata = imag_cnt;
      else
        r_d.rdata = 8'h00;
    end

    // soft blanking state machine
    case (r_q.st)
      ST_BLANKED:
      begin
        r_d.cur = '0;
        if (!BLANK_REQ_IN)
          r_d.st = ST_RAMP_UP; // [R12]
      end
      ST_RAMP_DOWN:
      begin
        if (!BLANK_REQ_IN)
          r_d.st = ST_RAMP_UP; // [R12]
        else if ({1'b0, r_q.cur} <= step_dn)
        begin
          r_d.cur = '0;
          r_d.st = ST_BLANKED; // [R12]
        end
        else
          r_d.cur = r_q.cur - step_dn[11:0]; // [R03]
      end
      ST_RAMP_UP:
      begin
        if (BLANK_REQ_IN)
          r_d.st = ST_RAMP_DOWN; // [R12]
        else if (up_sum >= {1'b0, r_q.gain})
        begin
          r_d.cur = r_q.gain;
          r_d.st = ST_DATA; // [R12]
        end
        else
          r_d.cur = up_sum[11:0]; // [R02]
      end
      default:
      begin
        r_d.cur = r_q.gain; // [R01]
        if (BLANK_REQ_IN)
          r_d.st = ST_RAMP_DOWN; // [R12]
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      r_q.gain <= {RST_Q_GAIN_HIGH, RST_Q_GAIN_LOW};
      r_q.up <= {RST_UP_HIGH, RST_UP_LOW};
      r_q.dn <= {RST_DN_HIGH, RST_DN_LOW};
      r_q.cfg1 <= RST_CFG_ONE;
      r_q.poly <= 1'b0;
      r_q.clr <= 1'b0;
      r_q.en <= 1'b0;
      r_q.st <= ST_BLANKED;
      r_q.cur <= '0;
      r_q.rdata <= 8'h00;
      r_q.rvalid <= 1'b0;
    end
    else
      r_q <= r_d;
  end

  assign REG_RDATA_OUT = r_q.rdata;
  assign REG_RVALID_OUT = r_q.rvalid;

  dgb_gain_mul u_mul (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .valid_in(SAMPLE_VALID_IN),
    .sample_in(SAMPLE_IMAG_IN),
    .gain_in(r_q.cur),
    .sample_out(Q_OUT),
    .valid_out(Q_VALID_OUT)
  );

  dgb_seq_chk u_chk_real (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .enable_in(r_q.en),
    .poly_in(r_q.poly),
    .clear_in(r_q.clr),
    .valid_in(SAMPLE_VALID_IN),
    .bit_in(SAMPLE_REAL_IN[SAMPLE_BIT]),
    .seq_ok_out(real_ok),
    .err_count_out(real_cnt)
  );

  dgb_seq_chk u_chk_imag (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .enable_in(r_q.en),
    .poly_in(r_q.poly),
    .clear_in(r_q.clr),
    .valid_in(SAMPLE_VALID_IN),
    .bit_in(SAMPLE_IMAG_IN[SAMPLE_BIT]),
    .seq_ok_out(imag_ok),
    .err_count_out(imag_cnt)
  );

  default clocking dgb_cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  property p_ramp_up;
    (r_q.st == ST_RAMP_UP && !BLANK_REQ_IN)
      |=> (r_q.st == ST_DATA
           || r_q.cur == 12'($past(r_q.cur) + $past(r_q.up) + 12'h001));
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("bad up step"); // [R02]

  property p_ramp_dn;
    (r_q.st == ST_RAMP_DOWN && BLANK_REQ_IN)
      |=> ((r_q.st == ST_BLANKED && r_q.cur == 12'h000)
           || r_q.cur == 12'($past(r_q.cur) - $past(r_q.dn) - 12'h001));
  endproperty
  a_ramp_dn: assert property (p_ramp_dn) else $error("bad down step"); // [R03]

  property p_data_gain;
    r_q.st == ST_DATA |-> r_q.cur == $past(r_q.gain);
  endproperty
  a_data_gain: assert property (p_data_gain) else $error("gain mismatch"); // [R01]

  property p_blank_zero;
    r_q.st == ST_BLANKED |-> r_q.cur == 12'h000;
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("blanked gain"); // [R12]

  property p_leave_data;
    (r_q.st == ST_DATA && BLANK_REQ_IN) |=> r_q.st == ST_RAMP_DOWN;
  endproperty
  a_leave_data: assert property (p_leave_data) else $error("no ramp down"); // [R12]

  property p_rb_down;
    (REG_RD_IN && REG_ADDR_IN == ADR_BLANK && r_q.st == ST_RAMP_DOWN)
      |=> (REG_RVALID_OUT && REG_RDATA_OUT == 8'h40);
  endproperty
  a_rb_down: assert property (p_rb_down) else $error("bad readback"); // [R04]

  property p_rb_data;
    (REG_RD_IN && REG_ADDR_IN == ADR_BLANK && r_q.st == ST_DATA)
      |=> REG_RDATA_OUT == 8'hc0;
  endproperty
  a_rb_data: assert property (p_rb_data) else $error("bad readback"); // [R04]

  property p_rb_blk;
    (REG_RD_IN && REG_ADDR_IN == ADR_BLANK && r_q.st == ST_BLANKED)
      |=> REG_RDATA_OUT == 8'h00;
  endproperty
  a_rb_blk: assert property (p_rb_blk) else $error("rb blank"); // [R04]

  property p_rb_up;
    (REG_RD_IN && REG_ADDR_IN == ADR_BLANK && r_q.st == ST_RAMP_UP)
      |=> REG_RDATA_OUT == 8'h80;
  endproperty
  a_rb_up: assert property (p_rb_up) else $error("bad readback"); // [R04]

  property p_rb_ok;
    (REG_RD_IN && REG_ADDR_IN == ADR_CHK_CTRL)
      |=> (REG_RDATA_OUT[FLD_IMAG_OK] == $past(imag_ok)
           && REG_RDATA_OUT[FLD_REAL_OK] == $past(real_ok));
  endproperty
  a_rb_ok: assert property (p_rb_ok) else $error("bad good flags"); // [R09]

  property p_err_re;
    (REG_RD_IN && REG_ADDR_IN == ADR_ERR_REAL)
      |=> REG_RDATA_OUT == $past(real_cnt);
  endproperty
  a_err_re: assert property (p_err_re) else $error("bad count"); // [R10]

  property p_err_im;
    (REG_RD_IN && REG_ADDR_IN == ADR_ERR_IMAG)
      |=> REG_RDATA_OUT == $past(imag_cnt);
  endproperty
  a_err_im: assert property (p_err_im) else $error("bad count"); // [R10]

  property p_chk_wr;
    (REG_WR_IN && REG_ADDR_IN == ADR_CHK_CTRL)
      |=> (r_q.en == $past(REG_WDATA_IN[FLD_EN])
           && r_q.clr == $past(REG_WDATA_IN[FLD_CLR]));
  endproperty
  a_chk_wr: assert property (p_chk_wr) else $error("control lost"); // [R06]

  c_ramp_down: cover property (r_q.st == ST_RAMP_DOWN ##1 r_q.st == ST_BLANKED);
  c_back_up: cover property (r_q.st == ST_RAMP_UP ##1 r_q.st == ST_DATA);
  c_err_read: cover property (REG_RD_IN && REG_ADDR_IN == ADR_ERR_REAL);
endmodule
`default_nettype wire

// ### verif/dgb_link_model.sv
// link transmitter model feeding sequence samples on both channels
// assumes bench sets run, pacing, polynomial and real-bit inversion
`timescale 1ns/1ps
`default_nettype none
module dgb_link_model
  import dgb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic poly_in,
  input wire logic inv_real_in,
  input wire logic [14:0] base_in,
  output logic valid_out,
  output logic [SAMPLE_W-1:0] real_out,
  output logic [SAMPLE_W-1:0] imag_out
);
  logic [SEQ_W-1:0] sr_q;
  logic phase_q;
  logic nb;

  // next bit of the chosen recurrence
  assign nb = poly_in ? (sr_q[14] ^ sr_q[13]) : (sr_q[6] ^ sr_q[5]);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sr_q <= 15'h7fff;
      phase_q <= 1'b0;
      valid_out <= 1'b0;
      real_out <= 16'h5a5a;
      imag_out <= 16'ha5a5;
    end
    else
    begin
      phase_q <= ~phase_q;
      if (run_in && (!slow_in || phase_q))
      begin
        sr_q <= {sr_q[13:0], nb};
        valid_out <= 1'b1;
        real_out <= {nb ^ inv_real_in, ~base_in};
        imag_out <= {nb, base_in};
      end
      else
      begin
        // idle lines never hold the last sample
        valid_out <= 1'b0;
        real_out <= ~real_out;
        imag_out <= ~imag_out;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/dgb_datapath_test.sv
// self-checking bench for the q gain, blanking and checker slice
// assumes link model drives samples, bench drives the register strobes
`timescale 1ns/1ps
`default_nettype none
module dgb_datapath_test
  import dgb_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic blank = 1'b1;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic poly = 1'b0;
  logic inv = 1'b0;
  logic [14:0] base = 15'h7000;
  logic sv;
  logic qv;
  logic rv;
  logic [15:0] sr;
  logic [15:0] si;
  logic [15:0] q;
  logic [15:0] cap1;
  logic [7:0] rdata;
  logic [11:0] ra [12] = '{12'h13e, 12'h13f, 12'h140, 12'h141, 12'h142,
    12'h143, 12'h146, 12'h147, 12'h14b, 12'h14c, 12'h14d, 12'h144};
  logic [7:0] re [12] = '{8'hea, 8'h0a, 8'h04, 8'h00, 8'h09, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    cap1 <= si;
  end

  dgb_datapath DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rv), .BLANK_REQ_IN(blank),
    .SAMPLE_VALID_IN(sv), .SAMPLE_REAL_IN(sr), .SAMPLE_IMAG_IN(si),
    .Q_OUT(q), .Q_VALID_OUT(qv));

  dgb_link_model link (.clk_in(clk), .rst_in(rst), .run_in(run),
    .slow_in(slow), .poly_in(poly), .inv_real_in(inv), .base_in(base),
    .valid_out(sv), .real_out(sr), .imag_out(si));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_reg(input logic [11:0] a, input logic [7:0] got,
    input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic cmp_q(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t q sample got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] qexp(input logic [15:0] x,
    input logic [11:0] g);
    longint p;
    p = (longint'($signed(x)) * longint'({1'b0, g})) >>> 11;
    if (p > 32767)
      p = 32767;
    if (p < -32768)
      p = -32768;
    return p[15:0];
  endfunction

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp_reg(a, (rv === 1'b1) ? rdata : 8'hxx, e);
  endtask

  task automatic check_q(input logic [11:0] g);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (qv !== 1'b1 && n < 20);
    cmp_q((qv === 1'b1) ? q : 16'hxxxx, qexp(cap1, g));
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++)
      reg_rd(ra[i], re[i]);
    reg_wr(12'h146, 8'h01);
    reg_rd(12'h146, 8'h01);
    for (int i = 1; i < 6; i += 2)
    begin
      reg_wr(ra[i], 8'hff);
      reg_rd(ra[i], 8'h0f);
    end
    reg_wr(12'h147, 8'hff);
    reg_rd(12'h147, 8'h00);
    reg_wr(12'h13e, 8'h64);
    reg_wr(12'h13f, 8'h00);
    reg_wr(12'h140, 8'h09);
    reg_wr(12'h141, 8'h00);
    reg_wr(12'h142, 8'h09);
    reg_wr(12'h143, 8'h00);
    run <= 1'b1;
    check_q(12'h000);
    @(posedge clk);
    blank <= 1'b0;
    repeat (2) @(posedge clk);
    reg_rd(12'h147, 8'h80);
    repeat (20) @(posedge clk);
    reg_rd(12'h147, 8'hc0);
    check_q(12'h064);
    @(posedge clk);
    blank <= 1'b1;
    repeat (2) @(posedge clk);
    reg_rd(12'h147, 8'h40);
    repeat (20) @(posedge clk);
    reg_rd(12'h147, 8'h00);
    check_q(12'h000);
    reg_wr(12'h140, 8'hff);
    reg_wr(12'h141, 8'h0f);
    reg_wr(12'h142, 8'h00);
    blank <= 1'b0;
    repeat (2) @(posedge clk);
    reg_rd(12'h147, 8'hc0);
    @(posedge clk);
    blank <= 1'b1;
    repeat (20) @(posedge clk);
    reg_rd(12'h147, 8'h40);
    repeat (100) @(posedge clk);
    reg_rd(12'h147, 8'h00);
    @(posedge clk);
    blank <= 1'b0;
    reg_wr(12'h13e, 8'h00);
    reg_wr(12'h13f, 8'h08);
    repeat (3) @(posedge clk);
    slow <= 1'b1;
    repeat (4) check_q(12'h800);
    reg_wr(12'h13e, 8'hff);
    reg_wr(12'h13f, 8'h0f);
    repeat (3) @(posedge clk);
    repeat (4) check_q(12'hfff);
    slow <= 1'b0;
    reg_wr(12'h14b, 8'h01);
    repeat (30) @(posedge clk);
    reg_wr(12'h14b, 8'h03);
    reg_wr(12'h14b, 8'h01);
    repeat (30) @(posedge clk);
    reg_rd(12'h14b, 8'hc1);
    reg_rd(12'h14c, 8'h00);
    reg_rd(12'h14d, 8'h00);
    @(posedge clk);
    inv <= 1'b1;
    @(posedge clk);
    inv <= 1'b0;
    repeat (20) @(posedge clk);
    reg_rd(12'h14c, 8'h03);
    reg_rd(12'h14d, 8'h00);
    reg_rd(12'h14b, 8'hc1);
    poly <= 1'b1;
    reg_wr(12'h14b, 8'h05);
    repeat (40) @(posedge clk);
    reg_wr(12'h14b, 8'h07);
    reg_wr(12'h14b, 8'h05);
    repeat (40) @(posedge clk);
    reg_rd(12'h14b, 8'hc5);
    reg_rd(12'h14c, 8'h00);
    reg_rd(12'h14d, 8'h00);
    inv <= 1'b1;
    repeat (300) @(posedge clk);
    reg_rd(12'h14c, 8'hff);
    reg_rd(12'h14b, 8'h85);
    reg_wr(12'h14b, 8'h07);
    reg_rd(12'h14c, 8'h00);
    reg_wr(12'h14b, 8'h04);
    repeat (20) @(posedge clk);
    reg_rd(12'h14c, 8'h00);
    inv <= 1'b0;
    complete_run;
  end
endmodule
`default_nettype wire
